/* vout_limit_defines.vh */
// Purpose: Shared constants of the output-voltage limit and fault monitor.
// Assumes: Thresholds are unsigned linear values with 2^-13 volt per LSB.
// Notes:   Offsets are command codes of the management bus.
`ifndef VOUT_LIMIT_DEFINES_VH
`define VOUT_LIMIT_DEFINES_VH

// Command codes of the threshold and response settings.
`define CODE_OV_WARN       8'h42
`define CODE_UV_WARN       8'h43
`define CODE_UV_FAULT      8'h44
`define CODE_UV_ACTION     8'h45

// Field positions of the fault-response byte.
`define ACT_MODE_HI        7
`define ACT_MODE_LO        6
`define ACT_RETRY_HI       5
`define ACT_RETRY_LO       3
`define ACT_DELAY_HI       2
`define ACT_DELAY_LO       0
`define ACT_MODE_RETRY     2'h2
`define ACT_NO_RETRY       3'h0

// Bit positions in the output-voltage status byte.
`define SV_OV_WARN         6
`define SV_UV_WARN         5
`define SV_UV_FAULT        4

// Default thresholds as ratio numerator over a common denominator.
`define OV_WARN_NUM        24'h000071
`define UV_WARN_NUM        24'h000054
`define UV_FAULT_NUM       24'h000050
`define RATIO_DEN          24'h000064

// Timing: clock period, millisecond tick and retry step.
`define CLK_PERIOD_PS      5000
`define TICK_TIME_NS       1000000
`define TICK_CYCLES        ((`TICK_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define RETRY_UNIT_MS      9'h023

`endif

/* ms_tick_gen.v */
// Purpose: Produces a one-cycle enable pulse every millisecond.
// Assumes: Runs on the single system clock; reset is synchronous.
// Notes:   The period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`include "vout_limit_defines.vh"

module ms_tick_gen #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire ref_clk,
  input  wire rst,
  output reg  tick_q
);

  reg  [17:0] count_q;

  // Counts clock cycles and pulses once per period.
  always @(posedge ref_clk) begin
    if (rst) begin
      count_q <= 18'h00000;
      tick_q  <= 1'b0;
    end else if (count_q == TICK_CYCLES[17:0] - 18'h00001) begin
      count_q <= 18'h00000;
      tick_q  <= 1'b1;
    end else begin
      count_q <= count_q + 18'h00001;
      tick_q  <= 1'b0;
    end
  end

endmodule

/* vout_limit_fault_monitor.v */
// Purpose: Supervises output voltage against warning and fault thresholds.
// Assumes: Samples and power-good come from logic on ref_clk; enable and
//          bias-ok are pins and are synchronised here.
// Notes:   Settings are reached by command code through the command port.
// Function
// - Above overvoltage warning, set summary and warning bits, notify host.
// - A very fast overvoltage rise may leave the warning unrecorded.
// - Thresholds are two-byte unsigned values, 2^-13 volt per bit, 0 to 5.5 V; writes above 5.5 V are stored unchecked.
// - A retry waits until output voltage falls below the overvoltage warning.
// - Undervoltage warning masked while ramping, before power-good, when disabled.
// - On undervoltage warning, set summary and warning bits, notify host.
// - Undervoltage fault masked while ramping, before power-good, when disabled.
// - On undervoltage fault, set summary and fault bits, notify host.
// - Response mode 10 disables output and retries; other codes unused.
// - Fault response pulls alert low; status bit cleared only by clear-faults.
// - Retry field 000 keeps output disabled until the fault is cleared.
// - Nonzero retry field retries forever until turned off, bias lost, other fault.
// - Restart attempts start (delay field plus one) times 35 ms apart.
// - After the retry delay the turn-on delay still applies.
// - The response setting is one read-write bit-field byte.
// - Defaults load from setpoint strap ratios and configuration strap.
`timescale 1ns/1ps
`include "vout_limit_defines.vh"

module vout_limit_fault_monitor #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  input  wire        clear_faults,
  output reg  [15:0] rd_data_q,
  output reg         rd_valid_q,
  input  wire [15:0] vout_sample,
  input  wire        vout_valid,
  input  wire        power_good,
  input  wire        ramping,
  input  wire        other_fault,
  input  wire [7:0]  ton_delay_ms,
  input  wire        enable_pin,
  input  wire        bias_ok_pin,
  input  wire [15:0] setpoint_strap,
  input  wire [7:0]  cfg_strap,
  output reg  [7:0]  status_vout_q,
  output reg         status_word_vout_q,
  output reg         alert_line_o_q,
  output reg         alert_line_oe_q,
  output reg         output_on_q,
  output reg         retry_busy_q
);

  // Retry machine states.
  localparam ST_RUN     = 3'h0;
  localparam ST_LATCH   = 3'h1;
  localparam ST_DELAY   = 3'h2;
  localparam ST_WAIT_OV = 3'h3;
  localparam ST_TON     = 3'h4;

  reg  [15:0] ov_warn_q;
  reg  [15:0] uv_warn_q;
  reg  [15:0] uv_fault_q;
  reg  [7:0]  uv_action_q;
  reg         strap_pending_q;
  reg  [1:0]  en_sync_q;
  reg  [1:0]  bias_sync_q;
  reg         above_ov_q;
  reg         below_uvw_q;
  reg         below_uvf_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [8:0]  wait_q;
  reg  [8:0]  wait_d;
  reg         out_d;
  wire        tick;
  wire        run_ok;
  wire        uv_mask;
  wire        ov_hit;
  wire        uvw_hit;
  wire        uvf_hit;
  wire        is_retry_mode;
  wire [8:0]  retry_wait;
  wire [23:0] strap_wide;
  wire [23:0] ov_default;
  wire [23:0] uvw_default;
  wire [23:0] uvf_default;
  reg  [7:0]  status_d;

  // Millisecond enable that paces the retry and turn-on delays.
  ms_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick_q  (tick)
  );

  // Two-stage synchronisers for the enable and bias pins.
  always @(posedge ref_clk) begin
    if (rst) begin
      en_sync_q   <= 2'h0;
      bias_sync_q <= 2'h0;
    end else begin
      en_sync_q   <= {en_sync_q[0], enable_pin};
      bias_sync_q <= {bias_sync_q[0], bias_ok_pin};
    end
  end

  assign run_ok = en_sync_q[1] & bias_sync_q[1] & ~other_fault;

  // Default thresholds scaled from the setpoint strap.
  assign strap_wide  = {8'h00, setpoint_strap};
  assign ov_default  = (strap_wide * `OV_WARN_NUM) / `RATIO_DEN;
  assign uvw_default = (strap_wide * `UV_WARN_NUM) / `RATIO_DEN;
  assign uvf_default = (strap_wide * `UV_FAULT_NUM) / `RATIO_DEN;

  // Settings: straps caught once after reset release, then host writes.
  always @(posedge ref_clk) begin
    if (rst) begin
      strap_pending_q <= 1'b1;
      ov_warn_q       <= 16'h0000;
      uv_warn_q       <= 16'h0000;
      uv_fault_q      <= 16'h0000;
      uv_action_q     <= 8'h00;
    end else if (strap_pending_q) begin
      strap_pending_q <= 1'b0;
      ov_warn_q       <= (ov_default[23:16] != 8'h00) ? 16'hFFFF
                                                     : ov_default[15:0];
      uv_warn_q       <= uvw_default[15:0];
      uv_fault_q      <= uvf_default[15:0];
      uv_action_q     <= cfg_strap;
    end else if (cmd_valid && cmd_write) begin
      // Full 16-bit thresholds stored as written, 2^-13 V per bit.
      case (cmd_code)
        `CODE_OV_WARN: begin
          ov_warn_q <= cmd_wdata;
        end
        `CODE_UV_WARN: begin
          uv_warn_q <= cmd_wdata;
        end
        `CODE_UV_FAULT: begin
          uv_fault_q <= cmd_wdata;
        end
        `CODE_UV_ACTION: begin
          uv_action_q <= cmd_wdata[7:0];
        end
        default: begin
          uv_action_q <= uv_action_q;
        end
      endcase
    end
  end

  // Read answers one cycle after the request; unknown codes read zero.
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= cmd_valid & ~cmd_write;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          `CODE_OV_WARN: begin
            rd_data_q <= ov_warn_q;
          end
          `CODE_UV_WARN: begin
            rd_data_q <= uv_warn_q;
          end
          `CODE_UV_FAULT: begin
            rd_data_q <= uv_fault_q;
          end
          `CODE_UV_ACTION: begin
            rd_data_q <= {8'h00, uv_action_q};
          end
          default: begin
            rd_data_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  // Undervoltage checks sleep while ramping, before power-good, or when off.
  assign uv_mask = ramping | ~power_good | ~output_on_q | ~run_ok;

  // A crossing is the first sample beyond a threshold.
  // A rise faster than the sample rate may skip the warning window.
  assign ov_hit  = vout_valid & (vout_sample > ov_warn_q) & ~above_ov_q;
  assign uvw_hit = vout_valid & ~uv_mask & (vout_sample < uv_warn_q)
                 & ~below_uvw_q;
  assign uvf_hit = vout_valid & ~uv_mask & (vout_sample < uv_fault_q)
                 & ~below_uvf_q;

  // Beyond-threshold memory so a level gives one crossing per excursion.
  always @(posedge ref_clk) begin
    if (rst) begin
      above_ov_q  <= 1'b0;
      below_uvw_q <= 1'b0;
      below_uvf_q <= 1'b0;
    end else if (vout_valid) begin
      above_ov_q  <= vout_sample > ov_warn_q;
      below_uvw_q <= ~uv_mask & (vout_sample < uv_warn_q);
      below_uvf_q <= ~uv_mask & (vout_sample < uv_fault_q);
    end
  end

  // Sticky status bits; a new crossing wins over a same-cycle clear.
  always @* begin
    status_d = clear_faults ? 8'h00 : status_vout_q;
    if (ov_hit) begin
      status_d[`SV_OV_WARN] = 1'b1;
    end
    if (uvw_hit) begin
      status_d[`SV_UV_WARN] = 1'b1;
    end
    if (uvf_hit) begin
      status_d[`SV_UV_FAULT] = 1'b1;
    end
  end

  // Status outputs and the open-drain alert, pulled low while any bit is set.
  always @(posedge ref_clk) begin
    if (rst) begin
      status_vout_q      <= 8'h00;
      status_word_vout_q <= 1'b0;
      alert_line_o_q     <= 1'b0;
      alert_line_oe_q    <= 1'b0;
    end else begin
      status_vout_q      <= status_d;
      status_word_vout_q <= |status_d;
      alert_line_o_q     <= 1'b0;
      alert_line_oe_q    <= |status_d;
    end
  end

  // Response field decode and retry spacing in milliseconds.
  assign is_retry_mode = uv_action_q[`ACT_MODE_HI:`ACT_MODE_LO]
                       == `ACT_MODE_RETRY;
  assign retry_wait = ({6'h00, uv_action_q[`ACT_DELAY_HI:`ACT_DELAY_LO]}
                       + 9'h001) * `RETRY_UNIT_MS;

  // Retry machine: next state and output enable.
  always @* begin
    state_d = state_q;
    wait_d  = wait_q;
    out_d   = output_on_q;
    case (state_q)
      ST_RUN: begin
        out_d = run_ok;
        if (uvf_hit && is_retry_mode) begin
          out_d = 1'b0;
          if (uv_action_q[`ACT_RETRY_HI:`ACT_RETRY_LO] == `ACT_NO_RETRY) begin
            state_d = ST_LATCH;
          end else begin
            state_d = ST_DELAY;
            wait_d  = retry_wait - 9'h001;
          end
        end
      end
      ST_LATCH: begin
        out_d = 1'b0;
        if (clear_faults) begin
          state_d = ST_RUN;
        end
      end
      ST_DELAY: begin
        out_d = 1'b0;
        if (!run_ok) begin
          state_d = ST_RUN;
        end else if (tick) begin
          if (wait_q == 9'h000) begin
            state_d = ST_WAIT_OV;
          end else begin
            wait_d = wait_q - 9'h001;
          end
        end
      end
      ST_WAIT_OV: begin
        out_d = 1'b0;
        if (!run_ok) begin
          state_d = ST_RUN;
        end else if (!above_ov_q) begin
          state_d = ST_TON;
          wait_d  = {1'b0, ton_delay_ms};
        end
      end
      ST_TON: begin
        out_d = 1'b0;
        if (!run_ok) begin
          state_d = ST_RUN;
        end else if (wait_q == 9'h000) begin
          state_d = ST_RUN;
          out_d   = 1'b1;
        end else if (tick) begin
          wait_d = wait_q - 9'h001;
        end
      end
      default: begin
        state_d = ST_RUN;
        out_d   = 1'b0;
      end
    endcase
  end

  // Retry machine registers.
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q      <= ST_RUN;
      wait_q       <= 9'h000;
      output_on_q  <= 1'b0;
      retry_busy_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      wait_q       <= wait_d;
      output_on_q  <= out_d & ~strap_pending_q;
      retry_busy_q <= (state_d != ST_RUN);
    end
  end

endmodule

/* vout_limit_fault_monitor_properties.sv */
// Purpose: Concurrent checks on the ports of the output-voltage monitor.
// Assumes: No request falls in the strap-load cycle after reset.
// Notes:   The response byte is mirrored from writes so retry checks know the mode.
`timescale 1ns/1ps
module vout_limit_checker #(
  parameter TICK_CYCLES = 10
) (
  input logic        ref_clk,
  input logic        rst,
  input logic        cmd_valid,
  input logic        cmd_write,
  input logic [7:0]  cmd_code,
  input logic [15:0] cmd_wdata,
  input logic        clear_faults,
  input logic        rd_valid_q,
  input logic        vout_valid,
  input logic        power_good,
  input logic        ramping,
  input logic        enable_pin,
  input logic        bias_ok_pin,
  input logic [7:0]  cfg_strap,
  input logic [7:0]  status_vout_q,
  input logic        status_word_vout_q,
  input logic        alert_line_o_q,
  input logic        alert_line_oe_q,
  input logic        output_on_q,
  input logic        retry_busy_q
);
  reg [7:0]  act_q;
  reg [31:0] busy_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Mirror of the response byte and a count of cycles spent retrying.
  always @(posedge ref_clk) begin
    if (rst)
      act_q <= cfg_strap;
    else if (cmd_valid && cmd_write && cmd_code == 8'h45)
      act_q <= cmd_wdata[7:0];
    busy_q <= retry_busy_q ? busy_q + 32'h1 : 32'h0;
  end
  sequence s_uvf_retry;
    $rose(status_vout_q[4]) && act_q[7:6] == 2'h2;
  endsequence
  sequence s_restart;
    $fell(retry_busy_q) && output_on_q;
  endsequence
  property p_summary;
    status_word_vout_q == (|status_vout_q[6:4]);
  endproperty
  property p_alert;
    alert_line_oe_q == status_word_vout_q && !alert_line_o_q;
  endproperty
  property p_sticky;
    (($past(status_vout_q) & ~status_vout_q) != 8'h00) |-> $past(clear_faults);
  endproperty
  property p_read;
    rd_valid_q == ($past(cmd_valid) && !$past(cmd_write));
  endproperty
  property p_uvw_mask;
    vout_valid && (ramping || !power_good) && !status_vout_q[5] |=> !status_vout_q[5];
  endproperty
  property p_uvf_mask;
    vout_valid && (ramping || !power_good) && !status_vout_q[4] |=> !status_vout_q[4];
  endproperty
  property p_retry_off;
    s_uvf_retry |-> !output_on_q && retry_busy_q;
  endproperty
  property p_retry_gap;
    s_restart |-> busy_q >= ((act_q[2:0] + 1) * 35 - 1) * TICK_CYCLES;
  endproperty
  property p_pins;
    output_on_q |-> $past(bias_ok_pin, 3) && $past(enable_pin, 3);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");
  a_alert: assert property (p_alert) else $error("alert wrong");
  a_sticky: assert property (p_sticky) else $error("status lost");
  a_read: assert property (p_read) else $error("read answer wrong");
  a_uvw_mask: assert property (p_uvw_mask) else $error("warn not masked");
  a_uvf_mask: assert property (p_uvf_mask) else $error("fault not masked");
  a_retry_off: assert property (p_retry_off) else $error("no shutdown");
  a_retry_gap: assert property (p_retry_gap) else $error("retry early");
  a_pins: assert property (p_pins) else $error("on while pin low");
endmodule

bind vout_limit_fault_monitor vout_limit_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
  .rd_valid_q(rd_valid_q), .vout_valid(vout_valid), .power_good(power_good),
  .ramping(ramping), .enable_pin(enable_pin), .bias_ok_pin(bias_ok_pin),
  .cfg_strap(cfg_strap), .status_vout_q(status_vout_q),
  .status_word_vout_q(status_word_vout_q), .alert_line_o_q(alert_line_o_q),
  .alert_line_oe_q(alert_line_oe_q), .output_on_q(output_on_q),
  .retry_busy_q(retry_busy_q));

/* pmbus_host_model.sv */
// Purpose: Management host that issues one command at a time.
// Assumes: A request stands for exactly one rising edge.
// Notes:   Released lines show inverted data so stale values cannot pass.
`timescale 1ns/1ps
module pmbus_host_model (
  input  logic        ref_clk,
  input  logic [15:0] rd_data_q,
  input  logic        rd_valid_q,
  output logic        cmd_valid,
  output logic        cmd_write,
  output logic [7:0]  cmd_code,
  output logic [15:0] cmd_wdata
);
  // Idle bus at time zero.
  initial begin
    cmd_valid = 0;
    cmd_write = 0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // A host only programs ordered limits within the 5.5 V span.
  function logic legal(input logic [15:0] ov, input logic [15:0] uvw, input logic [15:0] uvf);
    legal = ov <= 16'hB000 && uvw < ov && uvf < uvw && uvf != 16'h0000;
  endfunction
  // Issue one command and return any read answer.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge ref_clk);
    #1;
    cmd_valid = 0;
    cmd_code = ~c;
    cmd_wdata = ~d;
    ok = w | (rd_valid_q === 1'b1);
    q = rd_data_q;
  endtask
endmodule

/* vout_limit_fault_monitor_bench.sv */
// Purpose: Self-checking bench for the output-voltage monitor.
// Assumes: The tick is shortened to 10 clock cycles.
// Notes:   Straps and limits are random from a fixed seed.
`timescale 1ns/1ps
module vout_limit_fault_monitor_bench;
  localparam TICK = 10;
  logic        ref_clk, rst, clear_faults, vout_valid, power_good, ramping, ok;
  logic        other_fault, enable_pin, bias_ok_pin, cmd_valid, cmd_write, rd_valid_q;
  logic        status_word_vout_q, alert_line_o_q, alert_line_oe_q, output_on_q, retry_busy_q;
  logic [7:0]  cmd_code, ton_delay_ms, cfg_strap, status_vout_q;
  logic [15:0] cmd_wdata, rd_data_q, vout_sample, setpoint_strap, q, ov, uvw, uvf;
  integer      seed, err_total, n_compared, i, t;
  vout_limit_fault_monitor #(.TICK_CYCLES(TICK)) vout_limit_fault_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .vout_sample(vout_sample),
    .vout_valid(vout_valid), .power_good(power_good), .ramping(ramping),
    .other_fault(other_fault), .ton_delay_ms(ton_delay_ms), .enable_pin(enable_pin),
    .bias_ok_pin(bias_ok_pin), .setpoint_strap(setpoint_strap), .cfg_strap(cfg_strap),
    .status_vout_q(status_vout_q), .status_word_vout_q(status_word_vout_q),
    .alert_line_o_q(alert_line_o_q), .alert_line_oe_q(alert_line_oe_q),
    .output_on_q(output_on_q), .retry_busy_q(retry_busy_q));
  pmbus_host_model pmbus_host_model_i (
    .ref_clk(ref_clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  // Free-running 200 MHz clock.
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Count one comparison and report it if it fails.
  task chk(input logic good, input string msg);
    n_compared = n_compared + 1;
    // An unknown result counts as a mismatch, never as a pass.
    if (good !== 1'b1) begin
      err_total = err_total + 1;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Default limit: strap times ratio, saturating at the top code.
  function logic [15:0] scale(input logic [15:0] s, input integer n);
    integer p;
    p = s * n / 100;
    scale = (p > 65535) ? 16'hFFFF : p[15:0];
  endfunction
  task rd(input logic [7:0] c, input logic [15:0] e);
    pmbus_host_model_i.xfer(1'b0, c, 16'h0000, q, ok);
    chk(ok && q === e, "read value");
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    pmbus_host_model_i.xfer(1'b1, c, d, q, ok);
  endtask
  task smp(input logic [15:0] v);
    @(posedge ref_clk);
    #1;
    vout_sample = v;
    vout_valid = 1;
    @(posedge ref_clk);
    #1;
    vout_valid = 0;
  endtask
  task clr;
    @(posedge ref_clk);
    #1;
    clear_faults = 1;
    @(posedge ref_clk);
    #1;
    clear_faults = 0;
    chk(status_vout_q === 8'h00 && alert_line_oe_q === 1'b0, "clear");
  endtask
  task wait_on(input integer lim);
    for (t = 0; t < lim && output_on_q !== 1'b1; t = t + 1) begin
      @(posedge ref_clk);
      #1;
    end
    if (output_on_q !== 1'b1) begin
      chk(1'b0, "wait expired");
      test_done;
    end
  endtask
  // Main sequence.
  initial begin
    seed = 32'hB3F0;
    err_total = 0;
    n_compared = 0;
    {rst, clear_faults, vout_valid, power_good, ramping, other_fault} = 6'h20;
    {enable_pin, bias_ok_pin, ton_delay_ms, vout_sample} = {2'h3, 8'h02, 16'h0000};
    setpoint_strap = 16'($random(seed));
    cfg_strap = 8'($random(seed));
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 0;
    rd(8'h42, scale(setpoint_strap, 113));
    rd(8'h43, scale(setpoint_strap, 84));
    rd(8'h44, scale(setpoint_strap, 80));
    rd(8'h45, {8'h00, cfg_strap});
    $display("test defaults done");
    do begin
      ov = 16'($random(seed));
      uvw = 16'($random(seed));
      uvf = 16'($random(seed));
    end while (!pmbus_host_model_i.legal(ov, uvw, uvf));
    wr(8'h42, ov);
    wr(8'h43, uvw);
    wr(8'h44, uvf);
    wr(8'h45, 16'hA580);
    rd(8'h42, ov);
    rd(8'h43, uvw);
    rd(8'h44, uvf);
    rd(8'h45, 16'h0080);
    $display("test registers done");
    smp(ov);
    smp(uvf - 16'h0001);
    chk(status_vout_q === 8'h00, "masked or equal");
    smp(ov + 16'h0001);
    chk(status_vout_q === 8'h40 && status_word_vout_q && alert_line_oe_q, "ov");
    clr;
    {power_good, ramping} = 2'h3;
    smp(uvw);
    smp(uvf - 16'h0001);
    chk(status_vout_q === 8'h00, "ramp mask");
    ramping = 0;
    smp(uvw);
    smp(uvw - 16'h0001);
    chk(status_vout_q === 8'h20 && status_word_vout_q && alert_line_oe_q, "uvw");
    clr;
    $display("test limits done");
    smp(uvw);
    smp(uvf - 16'h0001);
    chk(status_vout_q === 8'h30 && output_on_q === 1'b0, "uvf");
    repeat (500) @(posedge ref_clk);
    #1;
    chk(output_on_q === 1'b0, "latched");
    clr;
    wait_on(10);
    for (i = 0; i < 4; i = i + 1) begin
      if (i != 2) begin
        wr(8'h45, {8'h00, i[1:0], 6'h00});
        smp(uvw);
        smp(uvf - 16'h0001);
        chk(status_vout_q[4] === 1'b1 && output_on_q === 1'b1, "unused mode");
        clr;
      end
    end
    $display("test latch done");
    wr(8'h45, 16'h0088);
    smp(uvw);
    smp(uvf - 16'h0001);
    chk(output_on_q === 1'b0 && retry_busy_q === 1'b1, "retry start");
    smp(ov + 16'h0001);
    repeat (37 * TICK + 20) @(posedge ref_clk);
    #1;
    chk(output_on_q === 1'b0, "retry above ov");
    smp(uvw);
    wait_on(3 * TICK);
    chk(t >= TICK - 2, "turn-on delay");
    clr;
    wr(8'h45, 16'h0089);
    smp(uvw);
    smp(uvf - 16'h0001);
    wait_on(80 * TICK);
    chk(t >= 70 * TICK && t <= 73 * TICK, "retry interval");
    // A running retry is stopped first by lost bias, then by another fault.
    for (i = 0; i < 2; i = i + 1) begin
      clr;
      wait_on(10);
      smp(uvw);
      smp(uvf - 16'h0001);
      chk(retry_busy_q === 1'b1, "retry armed");
      if (i == 0) begin
        bias_ok_pin = 0;
      end else begin
        other_fault = 1;
      end
      repeat (6) @(posedge ref_clk);
      #1;
      chk(retry_busy_q === 1'b0 && output_on_q === 1'b0, "abort");
      {bias_ok_pin, other_fault} = 2'h2;
    end
    $display("test retry done");
    test_done;
  end
endmodule
